/* dv/load_switch_fault_supervisor_tb.sv */
// Self-checking bench for the load switch fault supervisor
`timescale 1ns/1ps
module load_switch_fault_supervisor_tb;
  import lsfs_pkg::*;
  // Short timers keep the run brief
  localparam longint unsigned BL = 20;
  localparam longint unsigned RT = 50;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pd, olc, scc, bat, ot, uv, ov, shut, sw, cp, cl, sfn, oln;
  logic [1:0] seen;
  int err_count, n_checks;
  lsfs_top #(.BLANK_CYCLES(BL), .RETRY_CYCLES(RT)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_down_input(pd), .open_load_cmp(olc),
    .short_cmp(scc), .out_above_supply_cmp(bat), .over_temp_cmp(ot),
    .undervoltage_lockout(uv), .overvoltage_lockout(ov), .switch_on(sw),
    .charge_pump_on(cp), .current_limit_on(cl), .short_fault_n(sfn),
    .open_load_n(oln));
  lsfs_host host (.pclk(pclk), .presetn(presetn), .shut_req(shut),
    .short_fault_n(sfn), .open_load_n(oln), .power_down_input(pd),
    .fault_seen(seen));
  // ----------------------------------------------------------------
  // Clock, checks and bus tasks
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Master holds the request until pready is seen at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Bounded wait for the switch level, then compare
  task wsw(input logic v, input int n);
    int i;
    i = 0;
    while (sw !== v && i < n) begin
      @(negedge pclk);
      i++;
    end
    chk(32'(sw), 32'(v));
    // Hand back on a rising edge so the next stimulus lands there
    @(posedge pclk);
  endtask
  // Hang guard well beyond the expected run length
  initial begin
    #100000;
    err_count++;
    conclude();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, olc, scc, bat, ot, uv, ov, shut} = '0;
    paddr = '0;
    pwdata = '0;
    err_count = 0;
    n_checks = 0;
    presetn = 1'b0;
    tick(20);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(32'({sw, cp, cl, sfn, oln}), 32'h3);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(q, CTRL_RST);
    apb(1'b1, 12'h010, 32'h1);
    chk(32'(e), 32'h1);
    chk(q, 32'h0);
    tick(6);
    chk(32'(sw), 32'h0);
    apb(1'b1, CTRL_OFS, 32'h1);
    wsw(1'b1, 20);
    chk(32'(cp), 32'h1);
    // Open load is flagged but the switch stays on
    olc <= 1'b1;
    tick(5);
    chk(32'({oln, sw, seen}), 32'h6);
    olc <= 1'b0;
    // Short that clears before blanking ends
    scc <= 1'b1;
    tick(6);
    chk(32'({cl, sw}), 32'h3);
    scc <= 1'b0;
    tick(BL + 10);
    chk(32'({sw, sfn}), 32'h3);
    // Persistent short runs blank and retry cycles
    scc <= 1'b1;
    tick(BL - 5);
    chk(32'(sw), 32'h1);
    wsw(1'b0, 20);
    chk(32'(sfn), 32'h0);
    tick(RT - 10);
    chk(32'({sw, sfn}), 32'h0);
    wsw(1'b1, 30);
    wsw(1'b0, BL + 10);
    chk(32'(sfn), 32'h0);
    scc <= 1'b0;
    wsw(1'b1, RT + 20);
    tick(8);
    chk(32'(sfn), 32'h1);
    // Power-down, then a battery short found at turn-on
    shut <= 1'b1;
    wsw(1'b0, 10);
    bat <= 1'b1;
    shut <= 1'b0;
    tick(10);
    chk(32'({sw, sfn, oln}), 32'h0);
    apb(1'b0, STAT_OFS, 32'h0);
    chk(q & 32'h3, 32'h0);
    bat <= 1'b0;
    wsw(1'b1, 20);
    // Thermal shutdown and recovery
    ot <= 1'b1;
    wsw(1'b0, 5);
    ot <= 1'b0;
    wsw(1'b1, 20);
    // Both supply lockouts
    for (int k = 0; k < 2; k++) begin
      if (k == 0) uv <= 1'b1;
      else ov <= 1'b1;
      wsw(1'b0, 5);
      chk(32'(cp), 32'h0);
      uv <= 1'b0;
      ov <= 1'b0;
      wsw(1'b1, 20);
    end
    apb(1'b1, CTRL_OFS, 32'h0);
    wsw(1'b0, 10);
    conclude();
  end
endmodule

/* dv/lsfs_host.sv */
// Host model that drives power-down and samples the fault lines
`timescale 1ns/1ps
module lsfs_host (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request from the test sequence
  input wire logic shut_req,
  // Fault lines from the supervisor
  input wire logic short_fault_n,
  input wire logic open_load_n,
  // Power-down drive and sampled faults
  output logic power_down_input,
  output logic [1:0] fault_seen
);
  // Registered drive, so the host never glitches the power-down pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_down_input <= 1'b0;
      fault_seen <= 2'b11;
    end else begin
      power_down_input <= shut_req;
      fault_seen <= {short_fault_n, open_load_n};
    end
  end
endmodule

/* hdl/lsfs_pkg.sv */
// Package of constants for the load switch fault supervisor
package lsfs_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned BLANK_MS = 100;
  localparam int unsigned RETRY_MS = 1500;
  localparam longint unsigned BLANK_CYC = 64'(BLANK_MS) * 1000 * CLK_MHZ;
  localparam longint unsigned RETRY_CYC = 64'(RETRY_MS) * 1000 * CLK_MHZ;
  localparam int CNT_W = 32;
  localparam int SYNC_W = 7;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam int CTRL_ENA_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CHECK = 3'b001,
    ST_ON = 3'b010,
    ST_BLANK = 3'b011,
    ST_RETRY = 3'b100,
    ST_BATT = 3'b101
  } lsfs_state_t;
endpackage

/* hdl/lsfs_top.sv */
// Fault supervisor for a high-side load switch
//
// Behaviour
// RULE1 - Open-load flag drives open_load_n low.
// RULE2 - Open load is only reported; the switch stays on.
// RULE3 - Fixed variant: open load below 20mV sense drop, via comparator.
// RULE4 - Short-current comparator starts the blanking timer.
// RULE5 - Current limit active while blanking runs.
// RULE6 - Short lasting all of blanking: short_fault_n low, switch off.
// RULE7 - Short clearing early resets blanking, no fault.
// RULE8 - After blanking expiry, retry interval off, then turn on.
// RULE9 - Persisting short repeats; indicator stays low through cycle.
// RULE10 - Blanking starts above the limit even below double limit.
// RULE11 - Blanking 100ms, retry 1500ms, fixed.
// RULE12 - Output-versus-supply check before every turn-on.
// RULE13 - Check runs on retry end and thermal recovery too.
// RULE14 - Failed check: switch off, both indicators low.
// RULE15 - Over-temperature turns the switch off at once.
// RULE16 - Re-enable only after temperature flag clears.
// RULE17 - Power-down input high keeps the switch off.
// RULE18 - Host holds power-down input low to operate.
// RULE19 - Undervoltage keeps switch and charge pump off.
// RULE20 - Overvoltage disables switch and charge pump at once.
// RULE21 - Flags synchronised; intervals counted in clock cycles.
// RULE22 - Lockouts force switch off and sequencer idle.
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module lsfs_top
  import lsfs_pkg::*;
#(
  parameter longint unsigned BLANK_CYCLES = BLANK_CYC,
  parameter longint unsigned RETRY_CYCLES = RETRY_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog comparator and lockout flags
  input wire logic power_down_input,
  input wire logic open_load_cmp,
  input wire logic short_cmp,
  input wire logic out_above_supply_cmp,
  input wire logic over_temp_cmp,
  input wire logic undervoltage_lockout,
  input wire logic overvoltage_lockout,
  // Switch control and fault indicators
  output logic switch_on,
  output logic charge_pump_on,
  output logic current_limit_on,
  output logic short_fault_n,
  output logic open_load_n
);
  // ----------------------------------------------------------------
  // Flag synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] raw_flags;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  assign raw_flags = {power_down_input, open_load_cmp, short_cmp,
                      out_above_supply_cmp, over_temp_cmp,
                      undervoltage_lockout, overvoltage_lockout};
  // Two flops per flag; only sync2 is read by logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= raw_flags; // RULE21
      sync2_r <= sync1_r;
    end
  end
  wire pd_s = sync2_r[6];
  wire ol_s = sync2_r[5];
  wire sc_s = sync2_r[4];
  wire batt_s = sync2_r[3];
  wire ot_s = sync2_r[2];
  wire uv_s = sync2_r[1];
  wire ov_s = sync2_r[0];

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  wire setup = psel && !penable;
  wire hit_ctrl = paddr == CTRL_OFS;
  wire hit_stat = paddr == STAT_OFS;
  wire unmapped = !(hit_ctrl || hit_stat);
  wire acc_done = psel && penable && pready_r;
  // Software enable acts like the host's power-down being released
  wire sw_off = !ctrl_r[CTRL_ENA_BIT];
  lsfs_state_t state_r;
  lsfs_state_t state_nxt;
  wire [31:0] stat_word = {20'h0_0000, 1'b0, state_r, ov_s, uv_s, ot_s,
                           sc_s, ol_s, pd_s, short_fault_n, open_load_n};
  assign prdata_nxt = hit_ctrl ? ctrl_r : (hit_stat ? stat_word : 32'h0);
  // No wait state: ready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && unmapped;
      if (setup) prdata_r <= pwrite ? 32'h0 : prdata_nxt;
      if (acc_done && pwrite && hit_ctrl) ctrl_r <= pwdata;
    end
  end
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Lockouts override the short-circuit sequence entirely
  wire lockout = pd_s || uv_s || ov_s || ot_s || sw_off; // RULE22
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic short_lat_r;
  logic short_lat_nxt;
  wire blank_end = cnt_r == CNT_W'(BLANK_CYCLES - 1);
  wire retry_end = cnt_r == CNT_W'(RETRY_CYCLES - 1);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    short_lat_nxt = short_lat_r;
    if (lockout) begin
      state_nxt = ST_IDLE; // RULE15 RULE17 RULE19 RULE20
      cnt_nxt = '0;
      short_lat_nxt = 1'b0;
    end else begin
      case (state_r)
        // Leaving a lockout always passes through the battery check
        ST_IDLE: begin
          state_nxt = ST_CHECK; // RULE16 RULE13
        end
        ST_CHECK: begin
          cnt_nxt = '0;
          if (batt_s) begin
            state_nxt = ST_BATT; // RULE12 RULE14
          end else begin
            state_nxt = ST_ON;
          end
        end
        ST_ON: begin
          cnt_nxt = '0;
          if (sc_s) begin
            state_nxt = ST_BLANK; // RULE4 RULE10
          end else begin
            short_lat_nxt = 1'b0; // RULE9
          end
        end
        ST_BLANK: begin
          if (!sc_s) begin
            state_nxt = ST_ON; // RULE7
            cnt_nxt = '0;
          end else if (blank_end) begin
            state_nxt = ST_RETRY; // RULE6 RULE11
            cnt_nxt = '0;
            short_lat_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
        ST_RETRY: begin
          if (retry_end) begin
            state_nxt = ST_CHECK; // RULE8 RULE13
            cnt_nxt = '0;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
        // Stays off while output still sits at supply, re-checks after
        ST_BATT: begin
          if (!batt_s) state_nxt = ST_CHECK;
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      short_lat_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      short_lat_r <= short_lat_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------
  wire on_nxt = (state_nxt == ST_ON) || (state_nxt == ST_BLANK);
  wire batt_nxt = state_nxt == ST_BATT;
  // Open load only flags; it never touches on_nxt
  wire ol_ind_nxt = (on_nxt && ol_s) || batt_nxt; // RULE1 RULE2 RULE3
  wire sc_ind_nxt = short_lat_nxt || batt_nxt; // RULE9 RULE14
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_on <= 1'b0;
      charge_pump_on <= 1'b0;
      current_limit_on <= 1'b0;
      short_fault_n <= 1'b1;
      open_load_n <= 1'b1;
    end else begin
      switch_on <= on_nxt;
      charge_pump_on <= !lockout; // RULE19 RULE20
      current_limit_on <= state_nxt == ST_BLANK; // RULE5
      short_fault_n <= !sc_ind_nxt; // RULE6
      open_load_n <= !ol_ind_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pd_off_a: assert property (pd_s |=> !switch_on) // RULE17
    else $error("switch on during power down");
  temp_off_a: assert property (ot_s |=> !switch_on) // RULE15
    else $error("switch on while hot");
  uv_off_a: assert property (uv_s |=> !switch_on && !charge_pump_on) // RULE19
    else $error("switch on under undervoltage");
  ov_off_a: assert property (ov_s |=> !charge_pump_on) // RULE20
    else $error("charge pump on in overvoltage");
  blank_lim_a: assert property (state_r == ST_BLANK |-> current_limit_on) // RULE5
    else $error("no current limit while blanking");
  early_clr_a: assert property (state_r == ST_BLANK && !sc_s // RULE7
    && !lockout |=> state_r == ST_ON && switch_on && $stable(short_fault_n))
    else $error("early clear not honoured");
  expiry_a: assert property (state_r == ST_BLANK && sc_s && blank_end // RULE6
    && !lockout |=> state_r == ST_RETRY && !short_fault_n && !switch_on)
    else $error("blanking expiry wrong");
  retry_chk_a: assert property (state_r == ST_RETRY && retry_end // RULE8
    && !lockout |=> state_r == ST_CHECK)
    else $error("retry does not end in check");
  batt_ind_a: assert property (state_r == ST_BATT |-> !switch_on // RULE14
    && !short_fault_n && !open_load_n)
    else $error("battery short indication wrong");
  on_chk_a: assert property ($rose(switch_on) |-> // RULE12
    $past(state_r) == ST_CHECK || $past(state_r) == ST_IDLE)
    else $error("turn on without check");
  ol_keep_a: assert property (state_r == ST_ON && ol_s // RULE1 RULE2
    && !lockout && !sc_s |=> switch_on && !open_load_n)
    else $error("open load handled wrong");
  // Open load clears the cycle after the synchronised flag does
  ol_clear_a: assert property (state_r == ST_ON && !ol_s // RULE1
    && !lockout |=> open_load_n)
    else $error("open load flag stuck");
  // Switch stays dark and the indicator low for the whole retry
  retry_off_a: assert property (state_r == ST_RETRY |-> // RULE8 RULE9
    !switch_on && !short_fault_n)
    else $error("switch or indicator wrong in retry");
  on_clean_a: assert property (state_r == ST_ON && !sc_s // RULE9
    && !lockout |=> switch_on && short_fault_n)
    else $error("cleared short still flagged");
  // A turn-on is always preceded by a cycle with the switch off
  check_off_a: assert property (state_r == ST_CHECK |-> !switch_on) // RULE12
    else $error("switch on during battery check");
  batt_ent_a: assert property (state_r == ST_CHECK && batt_s // RULE14
    && !lockout |=> state_r == ST_BATT && !switch_on)
    else $error("battery short not caught");
  idle_chk_a: assert property (state_r == ST_IDLE && !lockout // RULE13 RULE16
    |=> state_r == ST_CHECK)
    else $error("idle does not go to check");
  // Software disable and overvoltage both drop the switch
  ctrl_off_a: assert property (sw_off |=> !switch_on // RULE22
    && state_r == ST_IDLE)
    else $error("switch on while disabled");
  ov_sw_a: assert property (ov_s |=> !switch_on) // RULE20
    else $error("switch on in overvoltage");
  blank_cnt_a: assert property (state_r == ST_BLANK |-> // RULE11
    cnt_r < CNT_W'(BLANK_CYCLES))
    else $error("blanking count overrun");
  // Bus answers in the first access cycle and for one cycle only
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("ready held for two cycles");
  err_rdy_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  // Main paths through the sequencer
  blank_c: cover property (state_r == ST_BLANK ##1 state_r == ST_RETRY);
  retry_c: cover property (state_r == ST_RETRY ##1 state_r == ST_CHECK);
  batt_c: cover property (state_r == ST_BATT);
  clr_c: cover property (state_r == ST_BLANK ##1 state_r == ST_ON);
  ol_c: cover property (state_r == ST_ON && ol_s);
endmodule
